/* File: verilog/bpc_map.vh */
`ifndef BPC_MAP_VH
`define BPC_MAP_VH
`define BPC_OFF_DATA      12'h000
`define BPC_OFF_DIR       12'h004
`define BPC_OFF_OPTION    12'h008
`define BPC_OFF_INTCTL    12'h00C
`define BPC_OFF_STATUS    12'h010
`define BPC_OFF_MASK      12'h014
`define BPC_RST_DIR       8'hFF
`define BPC_RST_OPTION    8'hFF
`define BPC_RST_LATCH     8'h00
`define BPC_BIT_PUDIS     7
`define BPC_BIT_CHGFLAG   0
`define BPC_BIT_CHGEN     3
`define BPC_BIT_WAKE      1
`define BPC_STAT_CHG      0
`define BPC_STAT_WAKE     1
`endif

/* File: verilog/bpc_port.v */
`timescale 1ns/10ps
`include "bpc_map.vh"
module bpc_port #(
  parameter W = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output reg           pslverr,
  input  wire [W-1:0]  pin_in,
  output reg  [W-1:0]  pin_out,
  output reg  [W-1:0]  pin_oe,
  output reg  [W-1:0]  pullup_en,
  input  wire          sleep_req,
  output reg           sleeping,
  output reg           wake,
  output reg           irq
);
  // Three-stage pin synchroniser; a change counts once stages two and three agree
  reg  [W-1:0] s1_r;
  reg  [W-1:0] s2_r;
  reg  [W-1:0] s3_r;
  reg  [W-1:0] pins_r;
  reg  [W-1:0] pins_nxt;

  // Software-visible port state
  reg  [W-1:0] latch_r;
  reg  [W-1:0] latch_nxt;
  reg  [W-1:0] dir_r;
  reg  [W-1:0] option_r;
  reg  [W-1:0] mask_r;

  // Change detection and sleep
  reg  [3:0]   snap_r;
  reg          chg_flag_r;
  reg          chg_flag_nxt;
  reg          chg_en_r;
  reg  [1:0]   stat_r;
  reg  [1:0]   stat_nxt;
  reg          sleep_nxt;

  // Bus handshake
  reg          rdy_r;
  reg  [31:0]  rdata_nxt;

  wire         setup_acc;
  wire         acc;
  wire         wr;
  wire         a_dat;
  wire         a_dir;
  wire         a_opt;
  wire         a_ic;
  wire         a_st;
  wire         a_msk;
  wire         hit;
  wire         port_acc;
  wire [W-1:0] agree;
  wire [W-1:0] port_view;
  wire [3:0]   pin_miss;
  wire         mismatch;
  wire         clr_flag;
  wire [1:0]   stat_clr;
  genvar       gi;

  // First access cycle; the answer is prepared here
  assign setup_acc = psel & penable & ~rdy_r;
  // Transfer completes at the edge that samples pready high
  assign acc       = psel & penable & rdy_r;
  assign wr        = acc & pwrite;

  assign a_dat = (paddr == `BPC_OFF_DATA);
  assign a_dir = (paddr == `BPC_OFF_DIR);
  assign a_opt = (paddr == `BPC_OFF_OPTION);
  assign a_ic  = (paddr == `BPC_OFF_INTCTL);
  assign a_st  = (paddr == `BPC_OFF_STATUS);
  assign a_msk = (paddr == `BPC_OFF_MASK);
  assign hit   = a_dat | a_dir | a_opt | a_ic | a_st | a_msk;

  // Reads and writes of the data register both refresh the snapshot
  assign port_acc = acc & a_dat;

  // Stages two and three agree: the new level is trusted
  assign agree = ~(s2_r ^ s3_r);

  // Inputs show the pins, outputs show the latch
  assign port_view = (pins_r & dir_r) | (latch_r & ~dir_r);

  // Per-pin compare of the upper nibble, inputs only
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_miss
      assign pin_miss[gi] = dir_r[gi+4] & (pins_r[gi+4] ^ snap_r[gi]);
    end
  endgenerate

  assign mismatch = |pin_miss;

  // Flag clears by writing zero to its bit
  assign clr_flag = wr & a_ic & ~pwdata[`BPC_BIT_CHGFLAG];

  // Status bits are write-one-to-clear
  assign stat_clr = {2{wr & a_st}} & pwdata[1:0];

  assign pready = rdy_r;

  always @* begin
    pins_nxt = (s3_r & agree) | (pins_r & ~agree);
  end

  // Full-word writes replace every bit, so the modify step keeps none of the pins
  always @* begin
    latch_nxt = latch_r;
    if (wr && a_dat) begin
      latch_nxt = pwdata[W-1:0];
    end
  end

  // Set wins over clear; a lasting mismatch keeps setting the flag
  always @* begin
    chg_flag_nxt = chg_flag_r;
    if (mismatch) begin
      chg_flag_nxt = 1'b1;
    end else if (clr_flag) begin
      chg_flag_nxt = 1'b0;
    end
  end

  always @* begin
    stat_nxt                 = stat_r;
    stat_nxt[`BPC_STAT_CHG]  = mismatch | (stat_r[`BPC_STAT_CHG] & ~stat_clr[`BPC_STAT_CHG]);
    stat_nxt[`BPC_STAT_WAKE] = (sleeping & mismatch) |
                               (stat_r[`BPC_STAT_WAKE] & ~stat_clr[`BPC_STAT_WAKE]);
  end

  // Wake has priority so a held sleep request cannot swallow it
  always @* begin
    sleep_nxt = sleeping;
    if (sleeping && mismatch) begin
      sleep_nxt = 1'b0;
    end else if (sleep_req) begin
      sleep_nxt = 1'b1;
    end
  end

  always @* begin
    rdata_nxt = 32'h00000000;
    if (a_dat) begin
      rdata_nxt = {24'h000000, port_view};
    end else if (a_dir) begin
      rdata_nxt = {24'h000000, dir_r};
    end else if (a_opt) begin
      rdata_nxt = {24'h000000, option_r};
    end else if (a_ic) begin
      rdata_nxt = {28'h0000000, chg_en_r, 2'b00, chg_flag_r};
    end else if (a_st) begin
      rdata_nxt = {30'h0, stat_r};
    end else if (a_msk) begin
      rdata_nxt = {24'h000000, mask_r};
    end else begin
      rdata_nxt = 32'h00000000;
    end
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_r <= 1'b0;
    end else begin
      rdy_r <= setup_acc;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Filtered pin levels; a one-cycle glitch never reaches here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_r <= {W{1'b0}};
    end else begin
      pins_r <= pins_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= `BPC_RST_LATCH;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // All pins float after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= `BPC_RST_DIR;
    end else if (wr && a_dir) begin
      dir_r <= pwdata[W-1:0];
    end
  end

  // Resets to all ones, so the pull-ups start switched off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_r <= `BPC_RST_OPTION;
    end else if (wr && a_opt) begin
      option_r <= pwdata[W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= {W{1'b0}};
    end else if (wr && a_msk) begin
      mask_r <= pwdata[W-1:0];
    end
  end

  // Polling the port refreshes this and can hide a change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_r <= 4'h0;
    end else if (port_acc) begin
      snap_r <= pins_r[7:4];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_en_r <= 1'b0;
    end else if (wr && a_ic) begin
      chg_en_r <= pwdata[`BPC_BIT_CHGEN];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_flag_r <= 1'b0;
    end else begin
      chg_flag_r <= chg_flag_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 2'b00;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping <= 1'b0;
    end else begin
      sleeping <= sleep_nxt;
    end
  end

  // One-cycle pulse on the edge that ends sleep
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake <= 1'b0;
    end else begin
      wake <= sleeping & mismatch;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= `BPC_RST_LATCH;
    end else begin
      pin_out <= latch_r;
    end
  end

  // Enable is high while the pin is driven
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= {W{1'b0}};
    end else begin
      pin_oe <= ~dir_r;
    end
  end

  // Output pins never see the pull-up, whatever the option bit says
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_en <= {W{1'b0}};
    end else begin
      pullup_en <= dir_r & {W{~option_r[`BPC_BIT_PUDIS]}};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (chg_flag_r & chg_en_r) | (|(stat_r & mask_r[1:0]));
    end
  end

  // Read data is loaded once and stands with pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_acc && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // Unmapped offsets answer with an error; their writes are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_acc & ~hit;
    end
  end

endmodule

/* File: testbench/bpc_port_props.sv */
`timescale 1ns/10ps
module bpc_port_props #(parameter W = 8) (
  input wire         pclk, presetn, psel, penable, pwrite, pready, pslverr, wake,
  input wire [11:0]  paddr,
  input wire [31:0]  pwdata, prdata,
  input wire [W-1:0] pin_out, pin_oe, pullup_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire        acc = psel && penable && pready;
  reg [W-1:0] wd;
  always @(posedge pclk) if (acc && pwrite) wd <= pwdata[W-1:0];
  AST_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait");
  AST_ONE: assert property (pready |=> !pready) else $error("pready held");
  AST_ERR: assert property (pready && pslverr |-> prdata == 32'h0) else $error("refused data");
  AST_PUOUT: assert property (!(pullup_en & pin_oe)) else $error("pull-up on output");
  AST_PURST: assert property ($rose(presetn) |-> !pullup_en) else $error("pull-up on");
  AST_LATCH: assert property (acc && pwrite && paddr == 12'h000 |=> ##[0:1] pin_out == wd)
    else $error("latch");
  AST_DIR: assert property (acc && pwrite && paddr == 12'h004 |=> ##[0:1] pin_oe == ~wd)
    else $error("direction");
  AST_WAKE: assert property (wake |=> !wake) else $error("wake held");
endmodule
bind bpc_port bpc_port_props #(.W(W)) u_props (.*);

/* File: testbench/bpc_keypad.sv */
`timescale 1ns/10ps
module bpc_keypad (
  input  wire       clk,
  input  wire [7:0] key, drv, oe, pu,
  output wire [7:0] lvl
);
  reg [7:0] flt = 8'h00;
  always @(posedge clk) flt <= ~flt; // Unpulled inputs wander
  assign lvl = (oe & drv) | (~oe & ~key & (pu | flt));
endmodule

/* File: testbench/bpc_port_bench.sv */
`timescale 1ns/10ps
module bpc_port_bench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_req = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, rd;
  reg  [7:0]  key = 0;
  wire [31:0] prdata;
  wire [7:0]  pin_in, pin_out, pin_oe, pullup_en;
  wire        pready, pslverr, sleeping, wake, irq;
  integer     fails = 0, n_tests = 0, j, k;
  reg  [47:0] rows [7] = '{48'h0004000000FF, 48'h0008000000FF, 48'h10080000007F,
    48'h1004000000F0, 48'h1000000000A5, 48'h0000000000F5, 48'h001800000000};
  bpc_port dut (.*);
  bpc_keypad pad (.clk(pclk), .key(key), .drv(pin_out), .oe(pin_oe), .pu(pullup_en), .lvl(pin_in));
  initial forever #25 pclk = ~pclk;
  task chk(input string nm, input [31:0] seen, exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task must(input string nm, input v);
    chk(nm, v, 1);
    if (v !== 1'b1) tally_and_finish;
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    for (k = 0; k < 9 && pready !== 1'b1; k = k + 1) @(posedge pclk);
    rd = prdata;
    {psel, penable} <= 2'b00;
    must("pready", pready === 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (j = 0; j < 7; j = j + 1) begin
      bus(rows[j][44], rows[j][43:32], rows[j][31:0]);
      if (!rows[j][44]) chk("prdata", rd, rows[j][31:0]);
    end
    chk("pins", {pullup_en, pin_oe, pin_out}, 24'hF00FA5);
    bus(0, 12'h000, 0);
    bus(1, 12'h00C, 8);
    bus(1, 12'h010, 3);
    bus(1, 12'h014, 1);
    chk("irq idle", irq, 0);
    key[4] <= 1;
    // Waits on irq, no port polling
    for (k = 0; k < 20 && irq !== 1'b1; k = k + 1) @(posedge pclk);
    must("irq", irq);
    bus(1, 12'h00C, 8);
    bus(0, 12'h00C, 0);
    chk("intctl", rd, 9);
    bus(0, 12'h000, 0);
    chk("port", rd, 32'hE5);
    bus(1, 12'h00C, 8);
    bus(1, 12'h010, 1);
    bus(0, 12'h00C, 0);
    chk("intctl", rd, 8);
    chk("irq", irq, 0);
    sleep_req <= 1;
    repeat (4) @(posedge pclk);
    key[4] <= 0;
    for (k = 0; k < 20 && wake !== 1'b1; k = k + 1) @(posedge pclk);
    must("wake", wake);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    chk("reset outs", {pullup_en, pin_oe, irq}, 0);
    bus(0, 12'h008, 0);
    chk("option", rd, 32'hFF);
    tally_and_finish;
  end
endmodule
